// ==== flc_pkg.sv ====
// Shared constants, types and coding functions of the line codec.
// Assumes a 100 MHz core clock; line and MAC timing are derived here.
package flc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_NS = 10;
	// Serial bit time of the coded 100 Mb/s stream as seen by this model
	localparam int BIT100_NS = 80;
	localparam int BIT100_CYC = BIT100_NS / CLK_NS;
	localparam logic [3:0] BIT100_LAST = 4'(BIT100_CYC - 1);
	localparam logic [3:0] BIT100_HALF = 4'(BIT100_CYC / 2);
	localparam int BIT10_NS = 100;
	localparam int BIT10_CYC = BIT10_NS / CLK_NS;
	// A mid-bit edge comes no sooner than three quarters of a bit
	localparam logic [4:0] MID10_CYC = 5'((3 * BIT10_CYC) / 4);
	localparam int RXCLK10_NS = 400;
	localparam logic [4:0] RXCLK10_HALF = 5'(RXCLK10_NS / CLK_NS / 2 - 1);

	// ----------------------------------------------------------------
	// Scrambler and symbols
	// ----------------------------------------------------------------
	localparam int LFSR_W = 11;
	localparam logic [10:0] LFSR_SEED = 11'h7ff;
	localparam logic [3:0] LOCK_BITS = 4'ha;
	localparam logic [4:0] SYM_J = 5'h18;
	localparam logic [4:0] SYM_K = 5'h11;
	localparam logic [4:0] SYM_T = 5'h0d;
	localparam logic [4:0] SYM_R = 5'h07;
	localparam logic [4:0] SYM_IDLE = 5'h1f;
	localparam logic [7:0] SFD_BYTE = 8'hd5;
	localparam logic [7:0] SFD_INV = 8'h2a;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic dv;
		logic [3:0] d;
	} flc_nib_type;

	typedef enum logic [3:0] {
		TX_IDLE = 4'b0001,
		TX_SSD = 4'b0010,
		TX_DATA = 4'b0100,
		TX_ESD = 4'b1000
	} flc_tx_type;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic lfsr_fb(input logic [10:0] s);
		return s[10] ^ s[8];
	endfunction

	function automatic logic [4:0] enc4b5b(input logic [3:0] n);
		logic [4:0] c;
		unique case (n)
			4'h0: c = 5'h1e; 4'h1: c = 5'h09; 4'h2: c = 5'h14; 4'h3: c = 5'h15;
			4'h4: c = 5'h0a; 4'h5: c = 5'h0b; 4'h6: c = 5'h0e; 4'h7: c = 5'h0f;
			4'h8: c = 5'h12; 4'h9: c = 5'h13; 4'ha: c = 5'h16; 4'hb: c = 5'h17;
			4'hc: c = 5'h1a; 4'hd: c = 5'h1b; 4'he: c = 5'h1c; 4'hf: c = 5'h1d;
		endcase
		return c;
	endfunction

	// Returns {valid, nibble}; control and invalid codes give valid low
	function automatic logic [4:0] dec5b4b(input logic [4:0] s);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < 16; i++) begin
			if (enc4b5b(4'(i)) == s) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction

endpackage

// ==== flc_rx10.sv ====
// 10 Mb/s receive decoder: Manchester to NRZ, squelch gate, preamble
// strip and polarity fix. Inputs are already synchronised to clk_i.
`timescale 1ns/1ns
module flc_rx10 (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic en_i,
	input wire logic line_i,
	input wire logic sq_i,
	output flc_pkg::flc_nib_type nib_o,
	output logic stb_o,
	output logic inv_o
);
	logic prev, act, frm, pend;
	logic [4:0] cnt;
	logic [7:0] sh8;
	logic [1:0] nbit;
	logic [3:0] nsh;
	logic next_prev, next_act, next_frm, next_pend, next_stb, next_inv;
	logic [4:0] next_cnt;
	logic [7:0] next_sh8;
	logic [1:0] next_nbit;
	logic [3:0] next_nsh;
	flc_pkg::flc_nib_type next_nib;

	always_comb begin
		next_prev = line_i;
		next_act = act;
		next_frm = frm;
		next_pend = pend;
		next_stb = 1'b0;
		next_inv = inv_o;
		next_cnt = (cnt == 5'h1f) ? cnt : cnt + 5'h01;
		next_sh8 = sh8;
		next_nbit = nbit;
		next_nsh = nsh;
		next_nib = nib_o;
		if (!en_i || !sq_i) begin
			// Below squelch nothing may start the decoder
			next_act = 1'b0;
			next_frm = 1'b0;
			next_pend = 1'b0;
		end else if (!act) begin
			// First edge after squelch opens is taken as a mid-bit edge
			next_act = 1'b1;
			next_cnt = 5'h1f;
			next_sh8 = 8'h00;
		end else begin
			if (pend) begin
				next_pend = 1'b0;
				next_stb = 1'b1;
				next_nib.d = flc_pkg::SFD_BYTE[7:4];
			end
			if (line_i != prev && cnt >= flc_pkg::MID10_CYC) begin
				next_cnt = 5'h00;
				if (!frm) begin
					next_sh8 = {line_i, sh8[7:1]};
					if (next_sh8 == flc_pkg::SFD_BYTE ||
						next_sh8 == flc_pkg::SFD_INV) begin
						// Preamble dropped; frame opens with the delimiter
						next_inv = (next_sh8 == flc_pkg::SFD_INV);
						next_frm = 1'b1;
						next_pend = 1'b1;
						next_stb = 1'b1;
						next_nib.d = flc_pkg::SFD_BYTE[3:0];
						next_nbit = 2'h0;
					end
				end else begin
					next_nsh = {line_i ^ inv_o, nsh[3:1]};
					next_nbit = nbit + 2'h1;
					if (nbit == 2'h3) begin
						next_stb = 1'b1;
						next_nib.d = next_nsh;
					end
				end
			end
		end
		next_nib.dv = next_frm;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prev <= 1'b0;
			act <= 1'b0;
			frm <= 1'b0;
			pend <= 1'b0;
			stb_o <= 1'b0;
			inv_o <= 1'b0;
			cnt <= 5'h00;
			sh8 <= 8'h00;
			nbit <= 2'h0;
			nsh <= 4'h0;
			nib_o <= '0;
		end else begin
			prev <= next_prev;
			act <= next_act;
			frm <= next_frm;
			pend <= next_pend;
			stb_o <= next_stb;
			inv_o <= next_inv;
			cnt <= next_cnt;
			sh8 <= next_sh8;
			nbit <= next_nbit;
			nsh <= next_nsh;
			nib_o <= next_nib;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	AST_SQUELCH_GATE: assert property (!sq_i |=> !act ##1 !nib_o.dv)
		else $error("decoder active without squelch");
	AST_POL_FIX: assert property ($rose(nib_o.dv) |->
		inv_o == ($past(sh8, 1) != 8'h00 && $past(next_sh8) == flc_pkg::SFD_INV))
		else $error("polarity flag does not match delimiter");
	AST_SFD_FIRST: assert property ($rose(nib_o.dv) |->
		stb_o && nib_o.d == flc_pkg::SFD_BYTE[3:0] ##1
		stb_o && nib_o.d == flc_pkg::SFD_BYTE[7:4])
		else $error("frame did not start with delimiter");

endmodule // flc_rx10

// ==== flc_codec.sv ====
// Line codec top: 100 Mb/s transmit and receive coding path and the
// 10 Mb/s receive decoder, facing a nibble-wide MAC port.
// Assumes line pins and the transmit bit clock come from other domains.
//
// Summary of operation
// - 100M transmit order: 4B/5B, scramble, NRZ to NRZI, then MLT-3.
// - MAC nibbles are 4B/5B coded, then serialised to a bit stream for scrambling.
// - Scrambler is an 11-bit LFSR of period 2047, only at 100M.
// - Descrambler regenerates the same sequence and strips it.
// - Three-level receive symbols are turned back into NRZI.
// - Bit clock is recovered from NRZI edges, then NRZI becomes NRZ.
// - Received bits are descrambled first, then 4B/5B decoded.
// - Decoded bits are gathered into nibbles for the MAC.
// - 10M Manchester input is split into bit timing and NRZ data.
// - 10M decoding starts only once squelch is passed.
// - 10M receive clock to the MAC keeps running between frames.
// - 10M receive drops the preamble and starts with the delimiter.
// - 10M receive detects reversed pair polarity and inverts data.
`timescale 1ns/1ns
module flc_codec (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic speed100_i,
	input wire logic tx_en_i,
	input wire logic [3:0] txd_i,
	input wire logic line_clk_i,
	input wire logic rx_pos_i,
	input wire logic rx_neg_i,
	input wire logic rx10_i,
	input wire logic squelch_i,
	output logic tx_take_o,
	output logic tx_pos_o,
	output logic tx_neg_o,
	output flc_pkg::flc_nib_type rx_o,
	output logic rx_stb_o,
	output logic rx_clk_o,
	output logic pol_inv_o
);
	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	logic [1:0] lck_s, pos_s, neg_s, r10_s, sq_s;
	logic lck_d;
	logic [1:0] lvl_d;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lck_s <= 2'h0;
			pos_s <= 2'h0;
			neg_s <= 2'h0;
			r10_s <= 2'h0;
			sq_s <= 2'h0;
			lck_d <= 1'b0;
			lvl_d <= 2'h0;
		end else begin
			lck_s <= {lck_s[0], line_clk_i};
			pos_s <= {pos_s[0], rx_pos_i};
			neg_s <= {neg_s[0], rx_neg_i};
			r10_s <= {r10_s[0], rx10_i};
			sq_s <= {sq_s[0], squelch_i};
			lck_d <= lck_s[1];
			lvl_d <= {pos_s[1], neg_s[1]};
		end
	end

	// ----------------------------------------------------------------
	// 100M transmit
	// ----------------------------------------------------------------
	flc_pkg::flc_tx_type tx_st, next_tx_st;
	logic [4:0] tx_sym, next_tx_sym;
	logic [2:0] tx_bit, next_tx_bit;
	logic [10:0] tx_lfsr, next_tx_lfsr;
	logic tx_nrzi, next_tx_nrzi;
	logic [1:0] tx_ph, next_tx_ph;
	logic next_take, tick, ks, scr;

	assign tick = lck_s[1] & ~lck_d & speed100_i;

	always_comb begin
		next_tx_st = tx_st;
		next_tx_sym = tx_sym;
		next_tx_bit = tx_bit;
		next_tx_lfsr = tx_lfsr;
		next_tx_nrzi = tx_nrzi;
		next_tx_ph = tx_ph;
		next_take = 1'b0;
		ks = flc_pkg::lfsr_fb(tx_lfsr);
		scr = tx_sym[4] ^ ks;
		if (tick) begin
			// Scrambler runs only on 100M bit ticks
			next_tx_lfsr = {tx_lfsr[9:0], ks};
			next_tx_nrzi = tx_nrzi ^ scr;
			if (next_tx_nrzi != tx_nrzi) begin
				next_tx_ph = tx_ph + 2'h1;
			end
			next_tx_sym = {tx_sym[3:0], 1'b0};
			next_tx_bit = tx_bit + 3'h1;
			if (tx_bit == 3'h4) begin
				next_tx_bit = 3'h0;
				unique case (tx_st)
					flc_pkg::TX_IDLE: begin
						next_tx_sym = tx_en_i ? flc_pkg::SYM_J : flc_pkg::SYM_IDLE;
						if (tx_en_i) begin
							next_tx_st = flc_pkg::TX_SSD;
						end
					end
					flc_pkg::TX_SSD: begin
						next_tx_sym = flc_pkg::SYM_K;
						next_tx_st = flc_pkg::TX_DATA;
					end
					flc_pkg::TX_DATA: begin
						if (tx_en_i) begin
							next_tx_sym = flc_pkg::enc4b5b(txd_i);
							next_take = 1'b1;
						end else begin
							next_tx_sym = flc_pkg::SYM_T;
							next_tx_st = flc_pkg::TX_ESD;
						end
					end
					flc_pkg::TX_ESD: begin
						next_tx_sym = flc_pkg::SYM_R;
						next_tx_st = flc_pkg::TX_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_st <= flc_pkg::TX_IDLE;
			tx_sym <= flc_pkg::SYM_IDLE;
			tx_bit <= 3'h0;
			tx_lfsr <= flc_pkg::LFSR_SEED;
			tx_nrzi <= 1'b0;
			tx_ph <= 2'h0;
			tx_take_o <= 1'b0;
			tx_pos_o <= 1'b0;
			tx_neg_o <= 1'b0;
		end else begin
			tx_st <= next_tx_st;
			tx_sym <= next_tx_sym;
			tx_bit <= next_tx_bit;
			tx_lfsr <= next_tx_lfsr;
			tx_nrzi <= next_tx_nrzi;
			tx_ph <= next_tx_ph;
			tx_take_o <= next_take;
			tx_pos_o <= (next_tx_ph == 2'h1);
			tx_neg_o <= (next_tx_ph == 2'h3);
		end
	end

	// ----------------------------------------------------------------
	// 100M receive
	// ----------------------------------------------------------------
	logic rx_nrzi, rx_last, ds_lock, rx_al, rx_trans, rx_samp, nrz, plain;
	logic next_rx_nrzi, next_rx_last, next_ds_lock, next_rx_al;
	logic [3:0] dp_cnt, next_dp_cnt, ds_lcnt, next_ds_lcnt;
	logic [10:0] ds_lfsr, next_ds_lfsr;
	logic [9:0] win, next_win;
	logic [2:0] rx_bcnt, next_rx_bcnt;
	logic [4:0] dec;
	logic n100_stb;
	logic [3:0] n100_d;

	always_comb begin
		// Any level change of the sliced line is one NRZI transition
		rx_trans = ({pos_s[1], neg_s[1]} != lvl_d) && speed100_i;
		next_rx_nrzi = rx_nrzi ^ rx_trans;
		next_dp_cnt = (dp_cnt == flc_pkg::BIT100_LAST) ? 4'h0 : dp_cnt + 4'h1;
		if (rx_trans) begin
			next_dp_cnt = 4'h1;
		end
		rx_samp = (dp_cnt == flc_pkg::BIT100_HALF) && speed100_i;
		nrz = rx_nrzi ^ rx_last;
		plain = nrz ^ flc_pkg::lfsr_fb(ds_lfsr);
		next_rx_last = rx_last;
		next_ds_lfsr = ds_lfsr;
		next_ds_lock = ds_lock & speed100_i;
		next_ds_lcnt = ds_lcnt;
		next_win = win;
		next_rx_al = rx_al & speed100_i;
		next_rx_bcnt = rx_bcnt;
		n100_stb = 1'b0;
		n100_d = 4'h0;
		dec = 5'h00;
		if (rx_samp) begin
			next_rx_last = rx_nrzi;
			if (!ds_lock) begin
				// Idle line carries all ones, so the key is the inverted line bit
				next_ds_lfsr = {ds_lfsr[9:0], ~nrz};
				next_ds_lcnt = ds_lcnt + 4'h1;
				next_ds_lock = (ds_lcnt == flc_pkg::LOCK_BITS);
			end else begin
				next_ds_lfsr = {ds_lfsr[9:0], flc_pkg::lfsr_fb(ds_lfsr)};
				next_win = {win[8:0], plain};
				next_rx_bcnt = rx_bcnt + 3'h1;
				if (!rx_al && next_win == {flc_pkg::SYM_J, flc_pkg::SYM_K}) begin
					next_rx_al = 1'b1;
					next_rx_bcnt = 3'h0;
				end else if (rx_al && rx_bcnt == 3'h4) begin
					next_rx_bcnt = 3'h0;
					dec = flc_pkg::dec5b4b(next_win[4:0]);
					n100_stb = dec[4];
					n100_d = dec[3:0];
					next_rx_al = dec[4];
				end
			end
		end
		if (!speed100_i) begin
			next_ds_lcnt = 4'h0;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_nrzi <= 1'b0;
			rx_last <= 1'b0;
			dp_cnt <= 4'h0;
			ds_lfsr <= flc_pkg::LFSR_SEED;
			ds_lock <= 1'b0;
			ds_lcnt <= 4'h0;
			win <= 10'h000;
			rx_al <= 1'b0;
			rx_bcnt <= 3'h0;
		end else begin
			rx_nrzi <= next_rx_nrzi;
			rx_last <= next_rx_last;
			dp_cnt <= next_dp_cnt;
			ds_lfsr <= next_ds_lfsr;
			ds_lock <= next_ds_lock;
			ds_lcnt <= next_ds_lcnt;
			win <= next_win;
			rx_al <= next_rx_al;
			rx_bcnt <= next_rx_bcnt;
		end
	end

	// ----------------------------------------------------------------
	// 10M receive and MAC outputs
	// ----------------------------------------------------------------
	flc_pkg::flc_nib_type n10, next_rx;
	logic n10_stb, n10_inv, next_rx_stb, next_rx_clk;
	logic [4:0] cdiv, next_cdiv;

	flc_rx10 flc_rx10_inst (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.en_i(~speed100_i),
		.line_i(r10_s[1]),
		.sq_i(sq_s[1]),
		.nib_o(n10),
		.stb_o(n10_stb),
		.inv_o(n10_inv)
	);

	always_comb begin
		next_cdiv = cdiv + 5'h01;
		next_rx_clk = rx_clk_o;
		if (speed100_i) begin
			next_cdiv = 5'h00;
			next_rx_clk = rx_clk_o ^ rx_samp;
			next_rx = '{dv: next_rx_al, d: n100_stb ? n100_d : rx_o.d};
			next_rx_stb = n100_stb;
		end else begin
			// Free running divider so the MAC sees a clock in idle gaps
			if (cdiv >= flc_pkg::RXCLK10_HALF) begin
				next_cdiv = 5'h00;
				next_rx_clk = ~rx_clk_o;
			end
			next_rx = n10;
			next_rx_stb = n10_stb;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cdiv <= 5'h00;
			rx_clk_o <= 1'b0;
			rx_o <= '0;
			rx_stb_o <= 1'b0;
			pol_inv_o <= 1'b0;
		end else begin
			cdiv <= next_cdiv;
			rx_clk_o <= next_rx_clk;
			rx_o <= next_rx;
			rx_stb_o <= next_rx_stb;
			pol_inv_o <= n10_inv;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	AST_TX_SSD: assert property (tick && tx_bit == 3'h4 &&
		tx_st == flc_pkg::TX_IDLE && tx_en_i |=>
		tx_st == flc_pkg::TX_SSD && tx_sym == flc_pkg::SYM_J)
		else $error("frame did not open with J symbol");
	AST_TX_TAKE: assert property (tx_take_o |->
		$past(tx_st) == flc_pkg::TX_DATA && $past(tx_bit) == 3'h4)
		else $error("nibble taken outside a symbol boundary");
	AST_SCR_HOLD: assert property (!speed100_i |=> $stable(tx_lfsr))
		else $error("scrambler moved outside 100M mode");
	AST_MLT3_SEQ: assert property (tx_pos_o ##1 !tx_pos_o |-> !tx_neg_o)
		else $error("MLT-3 jumped from plus to minus");
	AST_NRZI_RX: assert property (rx_trans |=> rx_nrzi != $past(rx_nrzi))
		else $error("line change did not toggle NRZI");
	AST_CDR_MID: assert property (rx_trans ##1 !rx_trans [*3] |=>
		rx_samp)
		else $error("bit not sampled half a bit after edge");
	AST_DS_LOCK: assert property ($rose(ds_lock) |->
		$past(ds_lcnt) == flc_pkg::LOCK_BITS)
		else $error("descrambler locked early");
	AST_RX_ORDER: assert property (n100_stb |-> ds_lock && rx_al)
		else $error("nibble decoded before descrambling lock");
	AST_RXCLK10: assert property (!speed100_i && $past(!speed100_i, 1) &&
		$stable(rx_clk_o) [*8] ##1 $stable(rx_clk_o) [*8] ##1
		$stable(rx_clk_o) [*4] |=> $changed(rx_clk_o))
		else $error("10M receive clock stopped");

endmodule // flc_codec

// ==== flc_line_model.sv ====
// Far-side line model: free bit clock, 100M cable loopback, 10M source.
// Assumes the bench calls send10 only while the codec is in 10M mode.
`timescale 1ns/1ns
module flc_line_model (
	input wire logic tx_pos_i,
	input wire logic tx_neg_i,
	output logic line_clk_o,
	output logic rx_pos_o,
	output logic rx_neg_o,
	output logic rx10_o,
	output logic squelch_o
);
	logic busy;

	initial begin
		line_clk_o = 1'b0;
		rx10_o = 1'b0;
		squelch_o = 1'b0;
		busy = 1'b0;
		forever #40 line_clk_o = ~line_clk_o;
	end

	// Undriven line carries noise that only squelch keeps out
	always #30 if (!busy) rx10_o = ~rx10_o;

	// Cable looped back, so 100M receive decodes our own transmit
	assign rx_pos_o = tx_pos_i;
	assign rx_neg_o = tx_neg_i;

	// ----------------------------------------------------------------
	// 10M frame: 7 preamble bytes, delimiter, payload, LSB first
	// ----------------------------------------------------------------
	task automatic send10(input logic [7:0] b[$], input logic inv,
		input logic sq);
		logic [7:0] cur;
		logic bv;
		busy = 1'b1;
		squelch_o = sq;
		#200;
		for (int i = 0; i < 8 + b.size(); i++) begin
			cur = (i < 7) ? 8'h55 : ((i == 7) ? 8'hd5 : b[i - 8]);
			for (int k = 0; k < 8; k++) begin
				bv = cur[k] ^ inv;
				rx10_o = ~bv;
				#50;
				rx10_o = bv;
				#50;
			end
		end
		squelch_o = 1'b0;
		#100;
		busy = 1'b0;
	endtask
endmodule // flc_line_model

// ==== tb_fast_ethernet_line_codec.sv ====
// Self-checking bench of the line codec with a looped-back cable.
// Assumes the line model owns the bit clock and all line inputs.
`timescale 1ns/1ns
module tb_fast_ethernet_line_codec;
	logic clk_i, nrst_i, speed100_i, tx_en_i;
	logic [3:0] txd_i;
	logic line_clk_i, rx_pos_i, rx_neg_i, rx10_i, squelch_i;
	logic tx_take_o, tx_pos_o, tx_neg_o, rx_stb_o, rx_clk_o, pol_inv_o;
	flc_pkg::flc_nib_type rx_o;
	int failures = 0;
	int samples_checked = 0;
	logic [3:0] got[$];
	logic [1:0] lvl = 2'h0;
	logic [1:0] last_nz = 2'h0;

	flc_codec flc_codec_inst (.clk_i(clk_i), .nrst_i(nrst_i),
		.speed100_i(speed100_i), .tx_en_i(tx_en_i), .txd_i(txd_i),
		.line_clk_i(line_clk_i), .rx_pos_i(rx_pos_i), .rx_neg_i(rx_neg_i),
		.rx10_i(rx10_i), .squelch_i(squelch_i), .tx_take_o(tx_take_o),
		.tx_pos_o(tx_pos_o), .tx_neg_o(tx_neg_o), .rx_o(rx_o),
		.rx_stb_o(rx_stb_o), .rx_clk_o(rx_clk_o), .pol_inv_o(pol_inv_o));

	flc_line_model flc_line_model_inst (.tx_pos_i(tx_pos_o),
		.tx_neg_i(tx_neg_o), .line_clk_o(line_clk_i), .rx_pos_o(rx_pos_i),
		.rx_neg_o(rx_neg_i), .rx10_o(rx10_i), .squelch_o(squelch_i));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// ----------------------------------------------------------------
	// Shared helpers
	// ----------------------------------------------------------------
	task automatic check_val(input string name, input logic [15:0] exp,
		input logic [15:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic timeout(input string name);
		failures++;
		$display("MISMATCH %s expected done seen timeout", name);
		stop_test();
	endtask

	// Inputs change 1 ns after the edge, outputs are read there too
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk_i);
			#1;
		end
	endtask

	task automatic check_nibs(input string name, input logic [3:0] exp[$]);
		check_val(name, 16'(exp.size()), 16'(got.size()));
		foreach (exp[i]) begin
			check_val(name, {12'h0, exp[i]},
				(i < got.size()) ? {12'h0, got[i]} : 16'hffff);
		end
	endtask

	always begin
		@(posedge clk_i);
		#1;
		if (rx_stb_o === 1'b1) got.push_back(rx_o.d);
	end

	// A nonzero level must return through zero and alternate sign
	always @(posedge clk_i) begin
		if (nrst_i && {tx_pos_o, tx_neg_o} !== lvl) begin
			if (lvl !== 2'h0) begin
				check_val("mlt3_zero", 16'h0, {14'h0, tx_pos_o, tx_neg_o});
				last_nz <= lvl;
			end else begin
				check_val("mlt3_step", {14'h0, (last_nz === 2'h2) ? 2'h1 : 2'h2},
					{14'h0, tx_pos_o, tx_neg_o});
			end
			lvl <= {tx_pos_o, tx_neg_o};
		end
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_clk_idle();
		int n;
		logic prev;
		n = 0;
		prev = rx_clk_o;
		repeat (400) begin
			tick(1);
			if (rx_clk_o !== prev) n++;
			prev = rx_clk_o;
		end
		check_val("rx_clk_toggles", 16'h0014, 16'(n));
	endtask

	task automatic t_tx_frozen();
		int n;
		n = 0;
		tx_en_i = 1'b1;
		repeat (300) begin
			tick(1);
			if ({tx_take_o, tx_pos_o, tx_neg_o} !== 3'h0) n++;
		end
		tx_en_i = 1'b0;
		check_val("tx_quiet_10m", 16'h0, 16'(n));
	endtask

	task automatic t_rx10(input logic inv, input logic sq);
		logic [7:0] b[$];
		logic [3:0] exp[$];
		b = {8'h3c, 8'ha5};
		if (sq) exp = {4'h5, 4'hd, 4'hc, 4'h3, 4'h5, 4'ha};
		got.delete();
		flc_line_model_inst.send10(b, inv, sq);
		tick(60);
		check_nibs("rx10_nibbles", exp);
		if (sq) check_val("pol_inv", {15'h0, inv}, {15'h0, pol_inv_o});
		check_val("rx10_dv_end", 16'h0, {15'h0, rx_o.dv});
	endtask

	task automatic t_loop100();
		logic [3:0] exp[$];
		int w;
		int n;
		for (int i = 0; i < 16; i++) exp.push_back(4'(i));
		got.delete();
		speed100_i = 1'b1;
		tick(100);
		n = 0;
		repeat (176) begin
			tick(1);
			if ({tx_pos_o, tx_neg_o} !== lvl) n++;
		end
		// Plain idle would change level on all 22 bits; the LFSR breaks it
		check_val("idle_scrambled", 16'h1, {15'h0, n < 22});
		txd_i = exp[0];
		tx_en_i = 1'b1;
		foreach (exp[i]) begin
			w = 0;
			do begin
				tick(1);
				w++;
			end while (tx_take_o !== 1'b1 && w < 400);
			if (w >= 400) timeout("tx_take");
			if (i + 1 < exp.size()) txd_i = exp[i + 1];
		end
		tx_en_i = 1'b0;
		w = 0;
		while (got.size() < 16 && w < 3000) begin
			tick(1);
			w++;
		end
		if (w >= 3000) timeout("rx100_nibbles");
		tick(300);
		check_nibs("loop100", exp);
		check_val("rx100_dv_end", 16'h0, {15'h0, rx_o.dv});
	endtask

	initial begin
		nrst_i = 1'b0;
		speed100_i = 1'b0;
		tx_en_i = 1'b0;
		txd_i = 4'h0;
		tick(10);
		check_val("reset_outs", 16'h0, {5'h00, tx_take_o, tx_pos_o, tx_neg_o,
			rx_o, rx_stb_o, rx_clk_o, pol_inv_o});
		tick(6);
		nrst_i = 1'b1;
		tick(10);
		t_clk_idle();
		t_tx_frozen();
		t_rx10(1'b0, 1'b1);
		t_rx10(1'b1, 1'b1);
		t_rx10(1'b0, 1'b0);
		t_loop100();
		stop_test();
	end
endmodule // tb_fast_ethernet_line_codec
